// [fcb_fanout_ctrl.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - Only address byte 11010010 (write) after start allows settings to change.
// - Second byte is a command byte: acknowledged, value ignored.
// - Third byte is a byte count: acknowledged, value ignored.
// - Ten bytes: address, command, count, data 0..6; only data 0..2 matter.
// - Bits arrive most significant first, bit 7 leading.
// - Sequence bytes four to six hold the three gate bytes.
// - First gate byte: bit 7 output 2, bit 2 output 1, bit 0 output 0.
// - Second gate byte: bit 6 output 5, bit 3 output 4.
// - Third gate byte: bit 7 output 3; other bits unused.
// - After reset all six outputs are enabled.
// - Device acknowledges each accepted byte by pulling data low.
// - Write only; the data line is driven only to acknowledge.
// - Data changing while clock is high marks a start or stop.
// - Start opens a transfer, stop closes it; bytes framed from start.
// - Gate data accepted only after start plus matching address.
// - Each gate bit is stored on the clock fall that ends its bit; outputs take it up in the reference's low phase.
// - A cut-short write leaves unreceived settings unchanged.
// - Stop or repeated start ends the current transfer.
// - Serial lines are only pulled low or released.
// - Enabled outputs follow the reference clock's edges.
module fcb_fanout_ctrl (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Reference clock to be fanned out
  input wire logic REF_CLK_IN,
  // Serial bus
  input wire logic SERIAL_CLOCK_LINE,
  input wire logic SERIAL_DATA_LINE_I,
  output logic SERIAL_DATA_LINE_O,
  output logic SERIAL_DATA_LINE_OE,
  // Gated copies of the reference
  output logic [fcb_pkg::NUM_OUT-1:0] FANOUT_CLOCK_OUTPUTS
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic scl_s;
  logic scl_p;
  logic sda_s;
  logic sda_p;
  logic ref_s;

  // Bus lines idle high, so reset the stages high to avoid a false start
  fcb_pin_sync #(
    .WIDTH(2),
    .RST_VAL(fcb_pkg::BUS_IDLE)
  ) u_bus_sync (
    .clk(CLK),
    .resetn(RESETN),
    .pin({SERIAL_CLOCK_LINE, SERIAL_DATA_LINE_I}),
    .level({scl_s, sda_s}),
    .level_prev({scl_p, sda_p})
  );

  // Reference input; its previous sample is not needed
  fcb_pin_sync #(
    .WIDTH(1),
    .RST_VAL(fcb_pkg::REF_IDLE)
  ) u_ref_sync (
    .clk(CLK),
    .resetn(RESETN),
    .pin(REF_CLK_IN),
    .level(ref_s),
    .level_prev()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus events

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  // Data moving under a high clock is framing, never a data bit
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Byte framing state

  fcb_pkg::fcb_state_t state_r;
  fcb_pkg::fcb_state_t state_nxt;
  logic [3:0] byte_idx_r;
  logic [3:0] byte_idx_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic oe_r;
  logic oe_nxt;
  logic byte_done;
  logic addr_ok;
  logic last_byte;

  // A gate byte sits at sequence positions four to six
  function automatic logic is_gate_byte(input logic [3:0] idx);
    is_gate_byte = (idx >= fcb_pkg::BYTE_IDX_GATE0) && (idx <= fcb_pkg::BYTE_IDX_GATE2);
  endfunction

  assign byte_done = scl_fall && (bit_cnt_r == fcb_pkg::BITS_PER_BYTE);
  assign addr_ok = (shift_r == fcb_pkg::ADDR_WRITE);
  assign last_byte = (byte_idx_r == fcb_pkg::BYTE_IDX_LAST);

  // Next state; start and stop override any bit activity
  always_comb begin
    state_nxt = state_r;
    byte_idx_nxt = byte_idx_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    oe_nxt = oe_r;
    if (start_ev) begin
      // A repeated start also lands here and restarts the count
      state_nxt = fcb_pkg::ST_RECV;
      byte_idx_nxt = fcb_pkg::BYTE_IDX_ADDR;
      bit_cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (stop_ev) begin
      state_nxt = fcb_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        fcb_pkg::ST_RECV: begin
          if (scl_rise && (bit_cnt_r < fcb_pkg::BITS_PER_BYTE)) begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (byte_done) begin
            if ((byte_idx_r == fcb_pkg::BYTE_IDX_ADDR) && !addr_ok) begin
              state_nxt = fcb_pkg::ST_SKIP;
            end else begin
              state_nxt = fcb_pkg::ST_ACK;
              oe_nxt = 1'b1;
            end
          end
        end
        fcb_pkg::ST_ACK: begin
          // Hold the low through the ninth clock, release on its fall
          if (scl_fall) begin
            oe_nxt = 1'b0;
            bit_cnt_nxt = 4'h0;
            if (last_byte) begin
              state_nxt = fcb_pkg::ST_SKIP;
            end else begin
              state_nxt = fcb_pkg::ST_RECV;
              byte_idx_nxt = byte_idx_r + 4'h1;
            end
          end
        end
        fcb_pkg::ST_SKIP: begin
          oe_nxt = 1'b0;
        end
        fcb_pkg::ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        default: begin
          state_nxt = fcb_pkg::ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // Framing registers
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_r <= fcb_pkg::ST_IDLE;
      byte_idx_r <= 4'h0;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      byte_idx_r <= byte_idx_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      oe_r <= oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate bytes, written bit by bit

  logic [7:0] output_gate_r [fcb_pkg::NUM_GATE_BYTES];
  logic gate_bit_wr;
  logic [2:0] gate_bit_pos;
  logic [1:0] gate_sel;

  // No shadow copy, but a bit lands on the fall that closes it: a rise that
  // turns into a stop or start must not overwrite a live setting
  assign gate_bit_wr = (state_r == fcb_pkg::ST_RECV) && scl_fall && !start_ev
    && !stop_ev && (bit_cnt_r != 4'h0)
    && is_gate_byte(byte_idx_r);
  assign gate_bit_pos = 3'(fcb_pkg::BITS_PER_BYTE - bit_cnt_r);
  assign gate_sel = 2'(byte_idx_r - fcb_pkg::BYTE_IDX_GATE0);

  generate
    for (genvar g = 0; g < fcb_pkg::NUM_GATE_BYTES; g++) begin : g_gate
      localparam logic [7:0] RST_V = (g == 0) ? fcb_pkg::GATE0_RST :
        (g == 1) ? fcb_pkg::GATE1_RST : fcb_pkg::GATE2_RST;
      // Bits not yet sent keep their old value
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          output_gate_r[g] <= RST_V;
        end else if (gate_bit_wr && (gate_sel == 2'(g))) begin
          output_gate_r[g][gate_bit_pos] <= shift_r[0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output gating

  logic [fcb_pkg::NUM_OUT-1:0] gate_want;
  logic [fcb_pkg::NUM_OUT-1:0] gate_app_r;
  logic [fcb_pkg::NUM_OUT-1:0] fanout_r;

  // Reserved bits are stored but steer nothing
  assign gate_want[0] = output_gate_r[0][fcb_pkg::POS_OUT0];
  assign gate_want[1] = output_gate_r[0][fcb_pkg::POS_OUT1];
  assign gate_want[2] = output_gate_r[0][fcb_pkg::POS_OUT2];
  assign gate_want[3] = output_gate_r[2][fcb_pkg::POS_OUT3];
  assign gate_want[4] = output_gate_r[1][fcb_pkg::POS_OUT4];
  assign gate_want[5] = output_gate_r[1][fcb_pkg::POS_OUT5];

  // Gate moves only in the low phase, so no pulse is ever clipped
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      gate_app_r <= '1;
    end else if (!ref_s) begin
      gate_app_r <= gate_want;
    end
  end

  // Outputs copy the reference, forced low where gated off
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      fanout_r <= '0;
    end else begin
      fanout_r <= {fcb_pkg::NUM_OUT{ref_s}} & gate_app_r;
    end
  end

  assign FANOUT_CLOCK_OUTPUTS = fanout_r;
  // Open drain: the data output only ever pulls low
  assign SERIAL_DATA_LINE_O = 1'b0;
  assign SERIAL_DATA_LINE_OE = oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_gate_bit;
    gate_bit_wr;
  endsequence

  sequence s_byte_end;
    (state_r == fcb_pkg::ST_RECV) && byte_done && !start_ev && !stop_ev;
  endsequence

  a_bit_takes_effect: assert property (s_gate_bit |=>
    output_gate_r[$past(gate_sel)][$past(gate_bit_pos)] == $past(shift_r[0]))
    else $error("gate bit not applied at once");

  a_addr_accept: assert property (s_byte_end ##0 (byte_idx_r == 4'h0)
    |=> (SERIAL_DATA_LINE_OE == $past(addr_ok)))
    else $error("address acknowledge mismatch");

  a_ack_held: assert property ((state_r == fcb_pkg::ST_ACK)
    |-> SERIAL_DATA_LINE_OE)
    else $error("acknowledge not driven");

  a_quiet_line: assert property ((state_r inside {fcb_pkg::ST_IDLE,
    fcb_pkg::ST_SKIP}) |-> !SERIAL_DATA_LINE_OE)
    else $error("data line driven outside acknowledge");

  a_hdr_no_effect: assert property (!is_gate_byte(byte_idx_r)
    |=> $stable(gate_want))
    else $error("non-gate byte changed a setting");

  a_skip_keeps: assert property ((state_r == fcb_pkg::ST_SKIP)
    |=> $stable(gate_want))
    else $error("settings changed after address mismatch");

  a_restart_frames: assert property (start_ev |=>
    (state_r == fcb_pkg::ST_RECV) && (byte_idx_r == 4'h0) && (bit_cnt_r == 4'h0))
    else $error("start did not restart framing");

  a_stop_ends: assert property (stop_ev && !start_ev |=>
    (state_r == fcb_pkg::ST_IDLE) ##1 !SERIAL_DATA_LINE_OE)
    else $error("stop did not end transfer");

  a_gate_hold_high: assert property (ref_s |=> $stable(gate_app_r))
    else $error("gate changed while reference high");

  a_out_follows: assert property ($rose(ref_s) |=>
    (FANOUT_CLOCK_OUTPUTS == gate_app_r) ##0 $past(ref_s))
    else $error("enabled outputs did not follow reference");

  a_reset_open: assert property ($rose(RESETN) |-> gate_app_r == '1)
    else $error("outputs not enabled after reset");

endmodule

// [fcb_host_model.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Bus host model: open-drain writer, 48 ns bit period, clock idles high
module fcb_host_model (
  // Wire lines, released level is the pull-up
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  // Both lines released at power-up
  initial begin
    scl <= 1'h1;
    sda_rel <= 1'h1;
  end

  // Start or repeated start: data falls while the clock is high
  // Non-blocking drive, so a change landing on a CLK edge is never raced
  task automatic start();
    sda_rel <= 1'h1;
    #12 scl <= 1'h1;
    #24 sda_rel <= 1'h0;
    #24 scl <= 1'h0;
    #12;
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    sda_rel <= 1'h0;
    #12 scl <= 1'h1;
    #24 sda_rel <= 1'h1;
    #24;
  endtask

  // Top nb bits of a byte, data moved mid-low; ack taken only on whole bytes
  task automatic send(input logic [7:0] b, input int nb, output logic ack_n);
    ack_n = 1'h1;
    for (int i = 7; i > 7 - nb; i--) begin
      sda_rel <= b[i];
      #12 scl <= 1'h1;
      #24 scl <= 1'h0;
      #12;
    end
    if (nb == 8) begin
      sda_rel <= 1'h1;
      #12 scl <= 1'h1;
      #12 ack_n = sda;
      #12 scl <= 1'h0;
      #12;
    end
  endtask
endmodule

// [fcb_pin_sync.sv]
`timescale 1ns/10ps
module fcb_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous pins
  input wire logic [WIDTH-1:0] pin,
  // Synchronised level and its previous sample
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] level_prev
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] prev_r;

  // First stage feeds only the second; edges come from stages two and three
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_r <= RST_VAL;
      level_r <= RST_VAL;
      prev_r <= RST_VAL;
    end else begin
      meta_r <= pin;
      level_r <= meta_r;
      prev_r <= level_r;
    end
  end

  assign level = level_r;
  assign level_prev = prev_r;

endmodule

// [fcb_pkg.sv]
package fcb_pkg;

  // Output count and serial framing
  localparam int NUM_OUT = 6;
  localparam logic [7:0] ADDR_WRITE = 8'hd2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BYTE_IDX_ADDR = 4'h0;
  localparam logic [3:0] BYTE_IDX_GATE0 = 4'h3;
  localparam logic [3:0] BYTE_IDX_GATE2 = 4'h5;
  localparam logic [3:0] BYTE_IDX_LAST = 4'h9;
  localparam int NUM_GATE_BYTES = 3;

  // Gate byte reset values: live bits set, reserved bits clear
  localparam logic [7:0] GATE0_RST = 8'h85;
  localparam logic [7:0] GATE1_RST = 8'h48;
  localparam logic [7:0] GATE2_RST = 8'h80;

  // Bit positions of each output's gate
  localparam int POS_OUT0 = 0;
  localparam int POS_OUT1 = 2;
  localparam int POS_OUT2 = 7;
  localparam int POS_OUT3 = 7;
  localparam int POS_OUT4 = 3;
  localparam int POS_OUT5 = 6;

  // Reset levels of the pin synchronisers
  localparam logic [1:0] BUS_IDLE = 2'h3;
  localparam logic [0:0] REF_IDLE = 1'h0;

  // Serial receiver states, Gray along idle-recv-ack-ignore
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RECV = 2'h1,
    ST_ACK = 2'h3,
    ST_SKIP = 2'h2
  } fcb_state_t;

endpackage

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic CLK = 1'h0;
  logic RESETN = 1'h0;
  logic REF_CLK_IN = 1'h0;
  logic ref_hold = 1'h0;
  logic [2:0] ref_cnt = 3'h0;
  wire scl;
  wire sda_rel;
  wire sda_o;
  wire sda_oe;
  wire [5:0] fan;
  // Open drain: device pull wins, otherwise the host level or pull-up
  wire sda = sda_oe ? 1'h0 : sda_rel;
  int err_total = 0;
  int cmp_count = 0;
  logic [7:0] tx [0:10];
  logic [7:0] gate [0:2] = '{8'hff, 8'hff, 8'hff};
  logic [5:0] held;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  always #2.5 CLK = ~CLK;

  // Reference of 8 CLK per half; a hold freezes it to test deferred gating
  always @(posedge CLK) begin
    ref_cnt <= ref_cnt + 3'h1;
    if (ref_cnt == 3'h7 && !ref_hold)
      REF_CLK_IN <= ~REF_CLK_IN;
  end

  fcb_fanout_ctrl uut (.CLK(CLK), .RESETN(RESETN), .REF_CLK_IN(REF_CLK_IN),
    .SERIAL_CLOCK_LINE(scl), .SERIAL_DATA_LINE_I(sda), .SERIAL_DATA_LINE_O(sda_o),
    .SERIAL_DATA_LINE_OE(sda_oe), .FANOUT_CLOCK_OUTPUTS(fan));
  fcb_host_model host (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Expected enables from the model's gate bytes
  function automatic logic [5:0] exp_mask();
    exp_mask = {gate[1][6], gate[1][3], gate[2][7], gate[0][7], gate[0][2], gate[0][0]};
  endfunction

  // Mid-high the outputs show the enables, mid-low all are low
  task automatic chk_out();
    @(posedge REF_CLK_IN);
    repeat (6) @(posedge CLK);
    #1 chk({2'h0, fan}, {2'h0, exp_mask()});
    @(negedge REF_CLK_IN);
    repeat (6) @(posedge CLK);
    #1 chk({2'h0, fan}, 8'h00);
  endtask

  // Address, two ignored bytes, gate bytes with reserved bits clear, filler
  task automatic fill(input logic [7:0] a);
    foreach (tx[k]) tx[k] = 8'($urandom);
    tx[0] = a;
    tx[3] &= 8'h85;
    tx[4] &= 8'h48;
    tx[5] &= 8'h80;
  endtask

  // Start, then n bytes with the last cut to nb bits; the model follows each bit
  task automatic xfer(input int n, input int nb);
    logic ack_n;
    logic hit;
    int w;
    hit = tx[0] === 8'hd2;
    host.start();
    for (int k = 0; k < n; k++) begin
      w = k == n - 1 ? nb : 8;
      host.send(tx[k], w, ack_n);
      for (int i = 7; i > 7 - w; i--)
        if (hit && k >= 3 && k <= 5) gate[k-3][i] = tx[k][i];
      if (w == 8) chk({7'h0, ack_n}, {7'h0, !(hit && k < 10)});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(47787));
    repeat (10) @(posedge CLK);
    RESETN <= 1'h1;
    repeat (10) @(posedge CLK);
    chk_out();
    for (int r = 0; r < 3; r++) begin
      fill(8'hd2);
      // Output 1 left on, so a stray bit from the later cut would show
      if (r == 2) tx[3] |= 8'h04;
      xfer(r == 0 ? 11 : 10, 8);
      host.stop();
      chk_out();
    end
    fill(8'hd2 ^ (8'h01 << 3'($urandom)));
    xfer(10, 8);
    host.stop();
    chk_out();
    // Cut after five bits: the stop's own clock pulse sits on output 1's bit
    fill(8'hd2);
    tx[3] = gate[0] ^ 8'h80;
    xfer(4, 5);
    chk_out();
    host.stop();
    chk_out();
    fill(8'hd2);
    xfer(4, 8);
    fill(8'hd2);
    xfer(6, 8);
    host.stop();
    chk_out();
    @(posedge REF_CLK_IN);
    ref_hold <= 1'h1;
    held = exp_mask();
    fill(8'hd2);
    tx[3] = ~gate[0] & 8'h85;
    xfer(6, 8);
    host.stop();
    #1 chk({2'h0, fan}, {2'h0, held});
    ref_hold <= 1'h0;
    chk_out();
    chk({7'h0, sda_o}, 8'h00);
    end_sim();
  end

  // Watchdog: the tests need some 5700 CLK, so cut a hang well past that
  initial begin
    #300000;
    err_total++;
    end_sim();
  end
endmodule
